// File: tmc_trigger_ctrl.sv
// Trigger system and reading store for the measurement front end.
// Assumes one command pulse at a time and a converter with start/done handshake.
//
// Overview of operation
// - Trigger source holds immediate or bus, host writable and readable, resets to immediate.
// - Immediate source fires a trigger at once on entering wait-for-trigger.
// - Bus trigger command accepted only in wait-for-trigger, otherwise rejected.
// - No trigger from any source is taken before wait-for-trigger is reached.
// - INIT only arms; conversion starts only when a trigger arrives.
// - Configure or measure commands force the source to immediate.
// - Factory reset or preset sets the source to immediate.
// - Source conflicting with settings reverts to immediate and raises a conflict error.
// - ABORt stops any measurement, waiting or running, and returns to idle.
// - Reset or preset aborts measurement and restores factory parameters.
// - FETCh copies stored readings out without erasing; repeats return same data.
// - FETCh does not complete until the pending measurement finishes.
// - Stored readings cleared on reset, preset, power-up, configuration change and INIT.
// - READ arms, measures on trigger, sends reading to memory and output buffer.
// - With immediate source READ behaves as INIT followed by FETCh.
// - With bus source READ is rejected with an error.
// - FETCh returns displayed value; READ returns raw data while averaging enabled.
// - Source query returns a string naming the selected source.
`timescale 1ns/1ps
`default_nettype none
module tmc_trigger_ctrl
  import tmc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Host command port
  input wire logic cmd_valid,
  input wire tmc_req_t cmd_req,
  // Settings status
  input wire logic src_conflict,
  input wire logic avg_enable,
  // Converter
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [TMC_DATA_W-1:0] conv_display,
  input wire logic [TMC_DATA_W-1:0] conv_raw,
  // Output buffer
  output var tmc_resp_t resp_reg,
  output logic resp_valid,
  output logic [TMC_NAME_W-1:0] name_reg,
  output logic name_valid,
  // Error and status
  output logic err_valid,
  output var tmc_err_t err_code,
  output var tmc_src_t src_reg,
  output logic busy
);

  typedef enum logic [1:0] {
    TMC_ST_IDLE,
    TMC_ST_WAIT,
    TMC_ST_MEAS
  } tmc_state_t;

  tmc_state_t state_reg;
  tmc_state_t state_next;
  logic store_valid_reg;
  logic [TMC_DATA_W-1:0] store_disp_reg;
  logic [TMC_DATA_W-1:0] store_raw_reg;
  logic fetch_pend_reg;
  logic read_pend_reg;
  logic resp_valid_reg;
  logic name_valid_reg;
  logic err_valid_reg;
  tmc_err_t err_code_reg;

  // Decoded command strobes
  logic c_set, c_query, c_init, c_read, c_fetch, c_trg, c_abort, c_rst, c_cfg;
  assign c_set = cmd_valid && cmd_req.cmd == TMC_CMD_SRC_SET;
  assign c_query = cmd_valid && cmd_req.cmd == TMC_CMD_SRC_QUERY;
  assign c_init = cmd_valid && cmd_req.cmd == TMC_CMD_INIT;
  assign c_read = cmd_valid && cmd_req.cmd == TMC_CMD_READ;
  assign c_fetch = cmd_valid && cmd_req.cmd == TMC_CMD_FETCH;
  assign c_trg = cmd_valid && cmd_req.cmd == TMC_CMD_TRG;
  assign c_abort = cmd_valid && cmd_req.cmd == TMC_CMD_ABORT;
  assign c_rst = cmd_valid && cmd_req.cmd == TMC_CMD_RESET;
  assign c_cfg = cmd_valid &&
    (cmd_req.cmd == TMC_CMD_CONFIG || cmd_req.cmd == TMC_CMD_MEASURE);

  // Arming commands; READ under bus source is refused
  logic read_ok, arm, trig_fire, trg_reject;
  assign read_ok = c_read && src_reg == TMC_SRC_IMM;
  assign arm = (c_init || read_ok) && state_reg == TMC_ST_IDLE;
  // Trigger only counts in wait state: immediate is always present
  assign trig_fire = state_reg == TMC_ST_WAIT &&
    (src_reg == TMC_SRC_IMM || c_trg);
  assign trg_reject = c_trg && state_reg != TMC_ST_WAIT;

  // Trigger state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TMC_ST_IDLE: begin
        if (arm) begin
          state_next = TMC_ST_WAIT;
        end
      end
      TMC_ST_WAIT: begin
        if (trig_fire) begin
          state_next = TMC_ST_MEAS;
        end
      end
      TMC_ST_MEAS: begin
        if (conv_done) begin
          state_next = TMC_ST_IDLE;
        end
      end
      default: state_next = TMC_ST_IDLE;
    endcase
    if (c_abort || c_rst || c_cfg) begin
      state_next = TMC_ST_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= TMC_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Conversion starts on the trigger itself
  assign conv_start = trig_fire && !(c_abort || c_rst || c_cfg);

  // Trigger source setting
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      src_reg <= TMC_SRC_RESET;
    end else if (c_rst) begin
      src_reg <= TMC_SRC_IMM;
    end else if (c_cfg) begin
      src_reg <= TMC_SRC_IMM;
    end else if (src_conflict && src_reg == TMC_SRC_BUS) begin
      src_reg <= TMC_SRC_IMM;
    end else if (c_set) begin
      src_reg <= cmd_req.src;
    end
  end

  // Reading memory: cleared on reset, configuration and each arm
  always_ff @(posedge clock) begin
    if (sys_rst || c_rst || c_cfg || arm) begin
      store_valid_reg <= 1'b0;
      store_disp_reg <= '0;
      store_raw_reg <= '0;
    end else if (state_reg == TMC_ST_MEAS && conv_done) begin
      store_valid_reg <= 1'b1;
      store_disp_reg <= conv_display;
      store_raw_reg <= conv_raw;
    end
  end

  // Pending FETCh and READ answers
  always_ff @(posedge clock) begin
    if (sys_rst || c_rst || c_abort || c_cfg) begin
      fetch_pend_reg <= 1'b0;
      read_pend_reg <= 1'b0;
    end else begin
      if (c_fetch) begin
        fetch_pend_reg <= 1'b1;
      end else if (resp_valid_reg && !read_pend_reg) begin
        fetch_pend_reg <= 1'b0;
      end
      if (arm && c_read) begin
        read_pend_reg <= 1'b1;
      end else if (resp_valid_reg) begin
        read_pend_reg <= 1'b0;
      end
    end
  end

  // Answer once no measurement is pending; memory is left intact
  logic ans_go;
  assign ans_go = (fetch_pend_reg || read_pend_reg) && !resp_valid_reg &&
    state_reg == TMC_ST_IDLE && store_valid_reg;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      resp_valid_reg <= 1'b0;
      resp_reg <= '0;
    end else begin
      resp_valid_reg <= ans_go;
      if (ans_go) begin
        // Raw data only for READ with averaging on
        resp_reg.raw <= read_pend_reg && avg_enable;
        resp_reg.data <= (read_pend_reg && avg_enable) ? store_raw_reg :
          store_disp_reg;
      end
    end
  end
  assign resp_valid = resp_valid_reg;

  // Source name answer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      name_valid_reg <= 1'b0;
      name_reg <= '0;
    end else begin
      name_valid_reg <= c_query;
      if (c_query) begin
        name_reg <= (src_reg == TMC_SRC_BUS) ? TMC_NAME_BUS : TMC_NAME_IMM;
      end
    end
  end
  assign name_valid = name_valid_reg;

  // Error reporting, one pulse per event
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      err_valid_reg <= 1'b0;
      err_code_reg <= TMC_ERR_NONE;
    end else begin
      err_valid_reg <= 1'b0;
      if (src_conflict && src_reg == TMC_SRC_BUS) begin
        err_valid_reg <= 1'b1;
        err_code_reg <= TMC_ERR_CONFLICT;
      end else if (c_read && src_reg == TMC_SRC_BUS) begin
        err_valid_reg <= 1'b1;
        err_code_reg <= TMC_ERR_READ_BUS;
      end else if (trg_reject) begin
        err_valid_reg <= 1'b1;
        err_code_reg <= TMC_ERR_TRG_REJECT;
      end
    end
  end
  assign err_valid = err_valid_reg;
  assign err_code = err_code_reg;
  assign busy = state_reg != TMC_ST_IDLE;

  // Checks on the trigger path
  a_abort_idle: assert property (@(posedge clock) disable iff (sys_rst)
    (c_abort || c_rst) |=> state_reg == TMC_ST_IDLE)
    else $error("abort left trigger armed");
  a_abort_stops: assert property (@(posedge clock) disable iff (sys_rst)
    c_abort |-> !conv_start)
    else $error("start issued with abort");
  a_imm_fires: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg == TMC_ST_WAIT && src_reg == TMC_SRC_IMM && !c_abort && !c_rst && !c_cfg)
    |-> conv_start)
    else $error("immediate trigger not fired");
  a_no_early_trig: assert property (@(posedge clock) disable iff (sys_rst)
    conv_start |-> state_reg == TMC_ST_WAIT)
    else $error("trigger outside wait");
  a_bus_holds: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg == TMC_ST_WAIT && src_reg == TMC_SRC_BUS && !c_trg) |-> !conv_start)
    else $error("bus source started without trigger");
  a_trg_in_wait: assert property (@(posedge clock) disable iff (sys_rst)
    (c_trg && state_reg == TMC_ST_WAIT) |-> conv_start)
    else $error("trigger in wait not taken");
  a_trg_reject: assert property (@(posedge clock) disable iff (sys_rst)
    (c_trg && state_reg == TMC_ST_IDLE) |=> err_valid)
    else $error("stray trigger not refused");
  a_meas_done: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg == TMC_ST_MEAS && conv_done) |=> state_reg == TMC_ST_IDLE)
    else $error("measurement did not end");

  // Checks on the source setting
  a_cfg_imm: assert property (@(posedge clock) disable iff (sys_rst)
    c_cfg |=> src_reg == TMC_SRC_IMM)
    else $error("configure kept bus source");
  a_rst_imm: assert property (@(posedge clock) disable iff (sys_rst)
    c_rst |=> src_reg == TMC_SRC_IMM && !store_valid_reg)
    else $error("reset not applied");
  a_conflict: assert property (@(posedge clock) disable iff (sys_rst)
    (src_conflict && src_reg == TMC_SRC_BUS) |=> src_reg == TMC_SRC_IMM
    && err_code == TMC_ERR_CONFLICT)
    else $error("conflict not reverted");
  a_name_bus: assert property (@(posedge clock) disable iff (sys_rst)
    (c_query && src_reg == TMC_SRC_BUS) |=> name_valid && name_reg == TMC_NAME_BUS)
    else $error("source name wrong");

  // Checks on the reading store and answers
  a_read_bus_err: assert property (@(posedge clock) disable iff (sys_rst)
    (c_read && src_reg == TMC_SRC_BUS && state_reg == TMC_ST_IDLE && !src_conflict)
    |=> err_valid && err_code == TMC_ERR_READ_BUS && state_reg == TMC_ST_IDLE)
    else $error("bus read not refused");
  a_read_arms: assert property (@(posedge clock) disable iff (sys_rst)
    (c_read && src_reg == TMC_SRC_IMM && state_reg == TMC_ST_IDLE)
    |=> state_reg == TMC_ST_WAIT && read_pend_reg && !store_valid_reg)
    else $error("immediate read did not arm");
  a_fetch_wait: assert property (@(posedge clock) disable iff (sys_rst)
    resp_valid |-> $past(state_reg) == TMC_ST_IDLE)
    else $error("fetch during measurement");
  a_fetch_disp: assert property (@(posedge clock) disable iff (sys_rst)
    (ans_go && !read_pend_reg) |=> resp_valid && !resp_reg.raw)
    else $error("fetch answered raw data");
  a_store_keeps: assert property (@(posedge clock) disable iff (sys_rst)
    (!cmd_valid && state_reg != TMC_ST_MEAS) |=> $stable(store_valid_reg)
    && $stable(store_disp_reg))
    else $error("readings changed without cause");
  a_capture: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg == TMC_ST_MEAS && conv_done && !cmd_valid) |=> store_valid_reg
    && store_disp_reg == $past(conv_display))
    else $error("reading not stored");
  a_init_clear: assert property (@(posedge clock) disable iff (sys_rst)
    arm |=> !store_valid_reg)
    else $error("arm kept old readings");

endmodule
`default_nettype wire

// File: tmc_pkg.sv
// Package for the trigger and readout controller: sources, commands, error codes, carriers.
// Assumes a command decoder upstream that presents one decoded command per pulse.
`default_nettype none
package tmc_pkg;

  // Trigger source values
  typedef enum logic {
    TMC_SRC_IMM,
    TMC_SRC_BUS
  } tmc_src_t;

  // Decoded host commands
  typedef enum logic [3:0] {
    TMC_CMD_NONE,
    TMC_CMD_SRC_SET,
    TMC_CMD_SRC_QUERY,
    TMC_CMD_INIT,
    TMC_CMD_READ,
    TMC_CMD_FETCH,
    TMC_CMD_TRG,
    TMC_CMD_ABORT,
    TMC_CMD_RESET,
    TMC_CMD_CONFIG,
    TMC_CMD_MEASURE
  } tmc_cmd_t;

  // Error codes reported with an error pulse
  typedef enum logic [1:0] {
    TMC_ERR_NONE,
    TMC_ERR_TRG_REJECT,
    TMC_ERR_READ_BUS,
    TMC_ERR_CONFLICT
  } tmc_err_t;

  // Reading width and source-name string width
  localparam int TMC_DATA_W = 32;
  localparam int TMC_NAME_W = 24;
  localparam logic [TMC_NAME_W-1:0] TMC_NAME_IMM = 24'h494D4D;
  localparam logic [TMC_NAME_W-1:0] TMC_NAME_BUS = 24'h425553;
  localparam tmc_src_t TMC_SRC_RESET = TMC_SRC_IMM;

  // One host command with its argument
  typedef struct packed {
    tmc_cmd_t cmd;
    tmc_src_t src;
  } tmc_req_t;

  // One answer placed in the output buffer
  typedef struct packed {
    logic [TMC_DATA_W-1:0] data;
    logic raw;
  } tmc_resp_t;

endpackage
`default_nettype wire

// File: tmc_conv_model.sv
// Converter model for the trigger controller's measurement side.
// Assumes the bench supplies the next reading and the latency in cycles.
`timescale 1ns/1ps
`default_nettype none
module tmc_conv_model
  import tmc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Bench control
  input wire logic [7:0] lat,
  input wire logic [TMC_DATA_W-1:0] disp_in,
  input wire logic [TMC_DATA_W-1:0] raw_in,
  // Converter handshake
  input wire logic conv_start,
  output logic conv_done,
  output logic [TMC_DATA_W-1:0] conv_display,
  output logic [TMC_DATA_W-1:0] conv_raw
);
  logic [7:0] cnt_reg;

  // Counts down the conversion time, restarting on every start pulse
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_reg <= 8'h00;
    end else if (conv_start) begin
      cnt_reg <= lat;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // Reading shows only with done; otherwise the lines carry its inverse
  assign conv_done = (cnt_reg == 8'h01);
  assign conv_display = conv_done ? disp_in : ~disp_in;
  assign conv_raw = conv_done ? raw_in : ~raw_in;
endmodule
`default_nettype wire

// File: trigger_measure_control_tb_top.sv
// Self-checking bench for the trigger and readout controller.
// Assumes the converter model file; commands are driven on falling edges.
`timescale 1ns/1ps
`default_nettype none
module trigger_measure_control_tb_top;
  import tmc_pkg::*;
  logic clock, sys_rst, cmd_valid, src_conflict, avg_enable, conv_start, conv_done;
  logic resp_valid, name_valid, err_valid, busy;
  tmc_req_t cmd_req;
  tmc_resp_t resp_reg;
  tmc_err_t err_code;
  tmc_src_t src_reg;
  logic [TMC_NAME_W-1:0] name_reg;
  logic [TMC_DATA_W-1:0] conv_display, conv_raw, disp_in, raw_in;
  logic [7:0] lat;
  logic [34:0] exp_q[$];
  int failures, check_count, starts, s0, seed;

  tmc_trigger_ctrl i_tmc_trigger_ctrl (.clock(clock), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_req(cmd_req), .src_conflict(src_conflict),
    .avg_enable(avg_enable), .conv_start(conv_start), .conv_done(conv_done),
    .conv_display(conv_display), .conv_raw(conv_raw), .resp_reg(resp_reg),
    .resp_valid(resp_valid), .name_reg(name_reg), .name_valid(name_valid),
    .err_valid(err_valid), .err_code(err_code), .src_reg(src_reg), .busy(busy));
  tmc_conv_model i_tmc_conv_model (.clock(clock), .sys_rst(sys_rst), .lat(lat),
    .disp_in(disp_in), .raw_in(raw_in), .conv_start(conv_start),
    .conv_done(conv_done), .conv_display(conv_display), .conv_raw(conv_raw));

  // Clock generation, 20 ns period
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input logic [34:0] got, input logic [34:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic note(input logic [34:0] e);
    exp_q.push_back(e);
  endtask

  // Takes the oldest note whenever an answer appears
  always @(negedge clock) begin
    if (resp_valid !== 1'b0) begin
      check({2'd0, resp_reg}, exp_q.size() ? exp_q.pop_front() : 'x);
    end
    if (name_valid !== 1'b0) begin
      check({2'd1, 9'h0, name_reg}, exp_q.size() ? exp_q.pop_front() : 'x);
    end
    if (err_valid !== 1'b0) begin
      check({2'd2, 31'h0, err_code}, exp_q.size() ? exp_q.pop_front() : 'x);
    end
  end

  // Counts converter start pulses
  always @(posedge clock) begin
    if (conv_start) starts++;
  end

  task automatic cmd(input tmc_cmd_t c, input tmc_src_t s = TMC_SRC_IMM);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_req = '{c, s};
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_req = '{TMC_CMD_NONE, TMC_SRC_IMM};
  endtask

  // Waits a bounded time for every noted answer, then reports the test
  task automatic settle(input string name);
    repeat (40) if (exp_q.size() != 0) @(negedge clock);
    repeat (2) @(negedge clock);
    $display("test %s done", name);
  endtask

  task automatic tally_and_finish;
    failures += exp_q.size();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog against a hung answer
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    tally_and_finish;
  end

  initial begin
    seed = 85955;
    cmd_valid = 1'b0;
    cmd_req = '{TMC_CMD_NONE, TMC_SRC_IMM};
    src_conflict = 1'b0;
    avg_enable = 1'b0;
    lat = 8'h05;
    disp_in = $random(seed);
    raw_in = $random(seed);
    sys_rst = 1'b1;
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
    check(35'(src_reg), 35'(TMC_SRC_IMM));
    note({2'd1, 9'h0, TMC_NAME_IMM});
    cmd(TMC_CMD_SRC_QUERY);
    cmd(TMC_CMD_SRC_SET, TMC_SRC_BUS);
    note({2'd1, 9'h0, TMC_NAME_BUS});
    cmd(TMC_CMD_SRC_QUERY);
    note({2'd2, 31'h0, TMC_ERR_TRG_REJECT});
    cmd(TMC_CMD_TRG);
    note({2'd2, 31'h0, TMC_ERR_READ_BUS});
    cmd(TMC_CMD_READ);
    settle("source");
    check(35'(busy), 35'h0);
    cmd(TMC_CMD_INIT);
    repeat (3) @(negedge clock);
    check(35'(busy), 35'h1);
    check(35'(starts), 35'h0);
    cmd(TMC_CMD_TRG);
    check(35'(starts), 35'h1);
    note({2'd0, disp_in, 1'b0});
    cmd(TMC_CMD_FETCH);
    settle("bus trigger");
    note({2'd0, disp_in, 1'b0});
    cmd(TMC_CMD_FETCH);
    settle("refetch");
    cmd(TMC_CMD_INIT);
    cmd(TMC_CMD_ABORT);
    check(35'(busy), 35'h0);
    src_conflict = 1'b1;
    note({2'd2, 31'h0, TMC_ERR_CONFLICT});
    settle("conflict");
    src_conflict = 1'b0;
    check(35'(src_reg), 35'(TMC_SRC_IMM));
    avg_enable = 1'b1;
    lat = 8'h01;
    disp_in = $random(seed);
    raw_in = $random(seed);
    s0 = starts;
    note({2'd0, raw_in, 1'b1});
    cmd(TMC_CMD_READ);
    settle("read");
    check(35'(starts - s0), 35'h1);
    avg_enable = 1'b0;
    note({2'd0, disp_in, 1'b0});
    cmd(TMC_CMD_FETCH);
    settle("fetch after read");
    for (int i = 0; i < 3; i++) begin
      cmd(TMC_CMD_SRC_SET, TMC_SRC_BUS);
      check(35'(src_reg), 35'(TMC_SRC_BUS));
      cmd(i == 0 ? TMC_CMD_CONFIG : i == 1 ? TMC_CMD_MEASURE : TMC_CMD_RESET);
      check(35'(src_reg), 35'(TMC_SRC_IMM));
    end
    settle("forced source");
    lat = 8'h30;
    cmd(TMC_CMD_SRC_SET, TMC_SRC_BUS);
    cmd(TMC_CMD_INIT);
    cmd(TMC_CMD_TRG);
    cmd(TMC_CMD_RESET);
    check(35'(busy), 35'h0);
    cmd(TMC_CMD_FETCH);
    repeat (60) @(negedge clock);
    cmd(TMC_CMD_ABORT);
    settle("reset clears");
    tally_and_finish;
  end
endmodule
`default_nettype wire
